// File: src/hmpu_defines.svh
`ifndef HMPU_DEFINES_SVH
`define HMPU_DEFINES_SVH
// Coprocessor encodings (opc1, CRn, CRm, opc2)
`define HMPU_CRN_PROT 4'h6
`define HMPU_OPC1_HYP 3'h4
`define HMPU_OPC2_ONE 3'h1
`define HMPU_CRM_ENABLE 4'h1
`define HMPU_CRM_SELECT 4'h2
`define HMPU_CRM_INDIRECT 4'h3
`define HMPU_OPC1_DIRECT_HI 2'h0
`define HMPU_CRM_DIRECT_TOP 1'h1
// Trap bit positions in the hypervisor system trap register
`define HMPU_TRAP_BIT_SIX 6
`define HMPU_TRAP_BIT_TEN 10
// Limit register field layout
`define HMPU_ADDR_MSB 31
`define HMPU_ADDR_LSB 6
`define HMPU_ATTR_MSB 3
`define HMPU_ATTR_LSB 1
`define HMPU_EN_BIT 0
`define HMPU_LOW_ONES 6'h3f
`define HMPU_LOW_ZEROS 6'h00
// Region count and reset values
`define HMPU_MAX_REGIONS 32
`define HMPU_NUM_REGIONS 6'h20
`define HMPU_ENABLE_RESET 32'h0000_0000
`endif

// File: src/hmpu_pkg.sv
package hmpu_pkg;
  typedef enum logic [2:0] {
    HMPU_NONE, HMPU_ENABLE, HMPU_SELECT, HMPU_ILIMIT, HMPU_DBASE, HMPU_DLIMIT
  } hmpu_target_t;
  typedef logic [25:0] hmpu_addr_t;
endpackage

// File: src/hmpu_region_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Per-region storage of upper address bits with registered read
module hmpu_region_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [25:0] wr_data,
  // Read port
  input wire logic [4:0] rd_idx,
  output logic [25:0] rd_data,
  // Flat view for address matching
  output logic [32*26-1:0] all_data
);
  typedef struct packed {
    logic [31:0][25:0] mem;
    logic [25:0] rd;
  } hmpu_mem_state_t;

  hmpu_mem_state_t st, next_st;

  // No reset: contents start undefined
  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.mem[wr_idx] = wr_data;
    end
    next_st.rd = st.mem[rd_idx];
  end

  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign rd_data = st.rd;
  assign all_data = st.mem;
endmodule
`default_nettype wire

// File: src/hmpu_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "hmpu_defines.svh"

// Function
// R01: Direct base n is opc1 00:n[4], CRm 1:n[3:1], opc2 n[0]:00.
// R02: Direct registers at or beyond the region count are unallocated encodings.
// R03: Lower-level direct base access traps when trap bit ten is set.
// R04: Enable mask bit n aliases region n enable; opc1 100 opc2 001 CRm 0001.
// R05: Mask bits of unimplemented regions read zero and ignore writes.
// R06: All region enables, and thus the mask, reset to zero.
// R07: Lower-level mask or indirect limit access traps when trap bit six set.
// R08: Indirect limit reaches selected region; opc1 100 opc2 001 CRm 0011.
// R09: Limit bits 31:6 give upper bound, low bits ones; bits 5:4 read zero.
// R10: Attribute index 0-3 picks low table fields, 4-7 high table fields.
// R11: Limit bit 0 enables its region; zero disables it.
// R12: Thirty-two direct limit registers share the indirect layout.
// R13: Limit and attribute index fields have no reset value.
// R14: Base bits 31:6 give inclusive lower bound, low bits zero.
// R15: Selector picks region for indirect access; software keeps it below count.
// R16: An address matches only an enabled region within both inclusive bounds.
// R17: Mask and per-region enables are one storage seen by both views.
module hmpu_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Coprocessor access from the core
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_opc1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_opc2,
  input wire logic [31:0] acc_wdata,
  input wire logic acc_from_kernel,
  output logic [31:0] acc_rdata,
  output logic acc_done,
  output logic acc_undef,
  output logic acc_trap,
  // Hypervisor context
  input wire logic hyp_present,
  input wire logic [31:0] hyp_sysreg_trap_reg,
  input wire logic [7:0] region_selector,
  // Address check
  input wire logic [31:0] chk_addr,
  output logic [31:0] region_hit,
  output logic [2:0] hit_attribute_selector,
  output logic hit_attribute_high_table
);
  // ----------------------------------------------------------------
  // State and local nets
  // ----------------------------------------------------------------
  // Registered state of the block, including limit enable and attribute fields; limit and base upper bits live in storage
  typedef struct packed {
    logic [31:0] enables;
    logic [31:0][2:0] attr;
    logic [31:0] rdata;
    logic done;
    logic undef;
    logic trap;
    logic rd_limit;
    logic rd_base;
    logic [31:0] hit;
    logic [2:0] hit_attr;
  } hmpu_state_t;

  hmpu_state_t st, next_st;
  // Decode results, storage views and matching
  hmpu_pkg::hmpu_target_t tgt;
  logic [4:0] idx;
  logic in_range;
  logic [31:0] impl_mask;
  logic mem_wr_lim;
  logic mem_wr_base;
  logic [25:0] lim_rd;
  logic [25:0] base_rd;
  logic [32*26-1:0] lim_all;
  logic [32*26-1:0] base_all;
  hmpu_pkg::hmpu_addr_t chk_hi;
  logic trap_six;
  logic trap_ten;
  logic [31:0] match_vec;
  logic [2:0] match_attr;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Implemented-region mask
  function automatic logic [31:0] impl_bits(input logic [5:0] cnt);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < `HMPU_MAX_REGIONS; i++) begin
      if (6'(i) < cnt) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Region index carried in a direct encoding
  function automatic logic [4:0] direct_idx(input logic [2:0] o1, input logic [3:0] cm,
                                            input logic [2:0] o2);
    return {o1[0], cm[2:0], o2[2]};
  endfunction

  // Lower-level access caught by one trap bit; hypervisor-level access never traps
  function automatic logic lower_trapped(input logic present, input logic kernel,
                                         input logic [31:0] traps, input int pos);
    return present && kernel && traps[pos];
  endfunction

  // Inclusive bound test on upper address bits
  function automatic logic in_bounds(input hmpu_pkg::hmpu_addr_t a,
                                     input hmpu_pkg::hmpu_addr_t lo,
                                     input hmpu_pkg::hmpu_addr_t hi);
    return a >= lo && a <= hi;
  endfunction

  // Fixed views of the inputs
  assign impl_mask = impl_bits(`HMPU_NUM_REGIONS);
  assign chk_hi = chk_addr[`HMPU_ADDR_MSB:`HMPU_ADDR_LSB];
  assign trap_six = lower_trapped(hyp_present, acc_from_kernel, hyp_sysreg_trap_reg,
                                  `HMPU_TRAP_BIT_SIX); // [R07]
  assign trap_ten = lower_trapped(hyp_present, acc_from_kernel, hyp_sysreg_trap_reg,
                                  `HMPU_TRAP_BIT_TEN); // [R03]

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Encoding decode; region index from the selector or from the encoding
  always_comb begin
    tgt = hmpu_pkg::HMPU_NONE;
    idx = region_selector[4:0]; // [R15]
    // Only the protection group is decoded; anything else is unallocated
    if (acc_crn != `HMPU_CRN_PROT) begin
      tgt = hmpu_pkg::HMPU_NONE;
    end else if (acc_opc1 == `HMPU_OPC1_HYP && acc_opc2 == `HMPU_OPC2_ONE &&
                 acc_crm == `HMPU_CRM_ENABLE) begin
      tgt = hmpu_pkg::HMPU_ENABLE; // [R04]
    end else if (acc_opc1 == `HMPU_OPC1_HYP && acc_opc2 == `HMPU_OPC2_ONE &&
                 acc_crm == `HMPU_CRM_INDIRECT) begin
      tgt = hmpu_pkg::HMPU_ILIMIT; // [R08]
    end else if (acc_opc1[2:1] == `HMPU_OPC1_DIRECT_HI &&
                 acc_crm[3] == `HMPU_CRM_DIRECT_TOP && acc_opc2[1:0] == 2'h0) begin
      // Base n: opc1 0:0:n[4], CRm 1:n[3:1], opc2 n[0]:0:0
      idx = direct_idx(acc_opc1, acc_crm, acc_opc2); // [R01]
      tgt = hmpu_pkg::HMPU_DBASE;
    end else if (acc_opc1[2:1] == `HMPU_OPC1_DIRECT_HI &&
                 acc_crm[3] == `HMPU_CRM_DIRECT_TOP && acc_opc2[1:0] == 2'h1) begin
      // Limit n differs from base n only in opc2 bit 0
      idx = direct_idx(acc_opc1, acc_crm, acc_opc2); // [R12]
      tgt = hmpu_pkg::HMPU_DLIMIT;
    end
    // Direct index beyond the implemented count is no storage [R02]
    in_range = impl_mask[idx];
  end

  // ----------------------------------------------------------------
  // Region storage
  // ----------------------------------------------------------------
  // Storage writes for limit and base upper bits
  // Refused or trapped accesses never reach storage
  assign mem_wr_lim = acc_valid && acc_write && !next_st.trap && !next_st.undef &&
                      (tgt == hmpu_pkg::HMPU_ILIMIT || tgt == hmpu_pkg::HMPU_DLIMIT);
  // Base words are written only through the direct encodings
  assign mem_wr_base = acc_valid && acc_write && !next_st.trap && !next_st.undef &&
                       tgt == hmpu_pkg::HMPU_DBASE;

  // Limit store, no reset [R13]
  hmpu_region_mem u_limit (
    .clk(clk),
    .wr_en(mem_wr_lim),
    .wr_idx(idx),
    .wr_data(acc_wdata[`HMPU_ADDR_MSB:`HMPU_ADDR_LSB]),
    .rd_idx(idx),
    .rd_data(lim_rd),
    .all_data(lim_all)
  );

  // Base store
  hmpu_region_mem u_base (
    .clk(clk),
    .wr_en(mem_wr_base),
    .wr_idx(idx),
    .wr_data(acc_wdata[`HMPU_ADDR_MSB:`HMPU_ADDR_LSB]),
    .rd_idx(idx),
    .rd_data(base_rd),
    .all_data(base_all)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = acc_valid;
    next_st.undef = 1'b0;
    next_st.trap = 1'b0;
    next_st.rd_limit = 1'b0;
    next_st.rd_base = 1'b0;
    next_st.rdata = 32'h0000_0000;
    // Refusals first: unknown encoding, then missing region, then traps
    if (acc_valid) begin
      if (tgt == hmpu_pkg::HMPU_NONE) begin
        next_st.undef = 1'b1;
      end else if ((tgt == hmpu_pkg::HMPU_DBASE || tgt == hmpu_pkg::HMPU_DLIMIT) &&
                   !in_range) begin
        next_st.undef = 1'b1; // [R02]
      end else if (trap_ten && tgt == hmpu_pkg::HMPU_DBASE) begin
        next_st.trap = 1'b1; // [R03]
      end else if (trap_ten && tgt == hmpu_pkg::HMPU_DLIMIT) begin
        next_st.trap = 1'b1;
      end else if (trap_six &&
                   (tgt == hmpu_pkg::HMPU_ENABLE || tgt == hmpu_pkg::HMPU_ILIMIT)) begin
        next_st.trap = 1'b1; // [R07]
      end else if (acc_write) begin
        if (tgt == hmpu_pkg::HMPU_ENABLE) begin
          next_st.enables = acc_wdata & impl_mask; // [R05] [R17]
        end else if (tgt != hmpu_pkg::HMPU_DBASE) begin
          // Indirect and direct limit share one layout [R12]
          next_st.enables[idx] = acc_wdata[`HMPU_EN_BIT] & in_range; // [R11] [R17]
          next_st.attr[idx] = acc_wdata[`HMPU_ATTR_MSB:`HMPU_ATTR_LSB];
        end
      end else begin
        if (tgt == hmpu_pkg::HMPU_ENABLE) begin
          next_st.rdata = st.enables & impl_mask; // [R05]
        end else if (tgt == hmpu_pkg::HMPU_DBASE) begin
          next_st.rd_base = 1'b1;
        end else begin
          next_st.rd_limit = 1'b1;
          // Bits 5:4 read zero [R09]
          next_st.rdata = {26'h0, 2'h0, st.attr[idx], st.enables[idx]};
        end
      end
    end
    // Match results registered for the outputs [R16]
    next_st.hit = match_vec;
    next_st.hit_attr = match_attr;
  end

  // ----------------------------------------------------------------
  // Address matching
  // ----------------------------------------------------------------
  // Compare the checked address with every enabled region [R16]
  always_comb begin
    match_vec = 32'h0000_0000;
    match_attr = 3'h0;
    for (int r = 0; r < `HMPU_MAX_REGIONS; r++) begin
      // Base low bits zero, limit low bits ones: compare upper bits only [R09] [R14]
      match_vec[r] = st.enables[r] && impl_mask[r] &&
                     in_bounds(chk_hi, base_all[r*26 +: 26], lim_all[r*26 +: 26]);
    end
    // Lowest-numbered hit region supplies the attribute index
    for (int r = `HMPU_MAX_REGIONS - 1; r >= 0; r--) begin
      if (match_vec[r]) begin
        match_attr = st.attr[r];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset clears enables and flags; storage keeps its contents
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= next_st;
      st.enables <= `HMPU_ENABLE_RESET; // [R06]
      st.done <= 1'b0;
      st.undef <= 1'b0;
      st.trap <= 1'b0;
      st.rd_limit <= 1'b0;
      st.rd_base <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.hit <= 32'h0000_0000;
      st.hit_attr <= 3'h0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Read data merges registered memory output with registered fields
  always_comb begin
    acc_rdata = st.rdata;
    if (st.rd_limit) begin
      acc_rdata = {lim_rd, st.rdata[5:0]}; // [R09]
    end else if (st.rd_base) begin
      acc_rdata = {base_rd, `HMPU_LOW_ZEROS}; // [R14]
    end
  end

  // Handshake flags and match results straight from the state register
  assign acc_done = st.done;
  assign acc_undef = st.undef;
  assign acc_trap = st.trap;
  assign region_hit = st.hit;
  // Index 4-7 selects the high attribute table [R10]
  assign hit_attribute_selector = st.hit_attr;
  assign hit_attribute_high_table = st.hit_attr[2];
endmodule
`default_nettype wire

// File: tb/hmpu_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hmpu_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access from the core
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_opc1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_opc2,
  input wire logic acc_from_kernel,
  input wire logic [31:0] acc_rdata,
  input wire logic acc_done,
  input wire logic acc_undef,
  input wire logic acc_trap,
  // Context and match
  input wire logic hyp_present,
  input wire logic [31:0] hyp_sysreg_trap_reg,
  input wire logic [31:0] region_hit,
  input wire logic [2:0] hit_attribute_selector,
  input wire logic hit_attribute_high_table
);
  logic six_acc;
  logic ten_acc;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Access classes guarded by trap bit six and trap bit ten
  assign six_acc = acc_valid && acc_crn == 4'h6 && acc_opc1 == 3'h4 && acc_opc2 == 3'h1
    && (acc_crm == 4'h1 || acc_crm == 4'h3);
  assign ten_acc = acc_valid && acc_crn == 4'h6 && acc_opc1[2:1] == 2'h0 && acc_crm[3]
    && !acc_opc2[1];
  property p_done; acc_valid |=> acc_done; endproperty
  a_done: assert property (p_done) else $error("answer missing");
  property p_idle; !acc_valid |=> !acc_done; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_flags; (acc_undef || acc_trap) |-> acc_done; endproperty
  a_flags: assert property (p_flags) else $error("flag outside answer");
  property p_six;
    six_acc && acc_from_kernel && hyp_present && hyp_sysreg_trap_reg[6] |=> acc_trap;
  endproperty
  a_six: assert property (p_six) else $error("bit six trap missing");
  property p_ten;
    ten_acc && acc_from_kernel && hyp_present && hyp_sysreg_trap_reg[10] |=> acc_trap;
  endproperty
  a_ten: assert property (p_ten) else $error("bit ten trap missing");
  property p_hyp; acc_valid && !(acc_from_kernel && hyp_present) |=> !acc_trap; endproperty
  a_hyp: assert property (p_hyp) else $error("trap at hypervisor level");
  property p_crn; acc_valid && acc_crn != 4'h6 |=> acc_undef; endproperty
  a_crn: assert property (p_crn) else $error("bad encoding accepted");
  property p_res; six_acc && !acc_write && acc_crm == 4'h3 |=> acc_rdata[5:4] == 2'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved limit bits set");
  property p_rst; disable iff (1'b0) !rst_n |=> region_hit == 32'h0 && !acc_done;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_tbl;
    hit_attribute_high_table == hit_attribute_selector[2] &&
    (region_hit != 32'h0 || hit_attribute_selector == 3'h0);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table pick wrong");
  c_trap: cover property (acc_trap);
  c_undef: cover property (acc_undef);
  c_hit: cover property (region_hit != 32'h0);
endmodule
bind hmpu_regs hmpu_chk u_chk (.clk, .rst_n, .acc_valid, .acc_write, .acc_opc1, .acc_crn,
  .acc_crm, .acc_opc2, .acc_from_kernel, .acc_rdata, .acc_done, .acc_undef, .acc_trap,
  .hyp_present, .hyp_sysreg_trap_reg, .region_hit, .hit_attribute_selector,
  .hit_attribute_high_table);
`default_nettype wire

// File: tb/hmpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmpu_core_model (
  // Clock
  input wire logic clk,
  // Request
  output logic acc_valid,
  output logic acc_write,
  output logic [2:0] acc_opc1,
  output logic [3:0] acc_crn,
  output logic [3:0] acc_crm,
  output logic [2:0] acc_opc2,
  output logic [31:0] acc_wdata,
  output logic acc_from_kernel,
  // Answer
  input wire logic [31:0] acc_rdata,
  input wire logic acc_done,
  input wire logic acc_undef,
  input wire logic acc_trap
);
  // Idle request lines
  initial begin
    acc_valid = 1'b0;
    {acc_write, acc_opc1, acc_crn, acc_crm, acc_opc2, acc_wdata, acc_from_kernel} = '0;
  end
  // One-cycle access pulse, answer taken when done shows
  task automatic access(input logic w, input logic [2:0] o1, input logic [3:0] crn,
      input logic [3:0] crm, input logic [2:0] o2, input logic [31:0] wd, input logic k,
      output logic [31:0] rd, output logic und, output logic trp);
    @(negedge clk);
    {acc_write, acc_opc1, acc_crn, acc_crm, acc_opc2, acc_wdata, acc_from_kernel} =
      {w, o1, crn, crm, o2, wd, k};
    acc_valid = 1'b1;
    @(negedge clk);
    acc_valid = 1'b0;
    acc_wdata = ~wd; // Stale data does not linger
    for (int n = 0; n < 4 && acc_done !== 1'b1; n++) @(negedge clk);
    rd = acc_rdata;
    und = acc_undef;
    trp = acc_trap;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, hyp_present, acc_valid, acc_write, acc_from_kernel;
  logic acc_done, acc_undef, acc_trap, hit_hi, und, trp;
  logic [2:0] acc_opc1, acc_opc2, hit_attr;
  logic [3:0] acc_crn, acc_crm;
  logic [31:0] acc_wdata, acc_rdata, trap_reg, chk_addr, region_hit, rd;
  logic [7:0] region_selector;
  int fails, num_checks, cycles;
  // Block and core model
  hmpu_regs DUT (.clk, .rst_n, .acc_valid, .acc_write, .acc_opc1, .acc_crn, .acc_crm,
    .acc_opc2, .acc_wdata, .acc_from_kernel, .acc_rdata, .acc_done, .acc_undef, .acc_trap,
    .hyp_present, .hyp_sysreg_trap_reg(trap_reg), .region_selector, .chk_addr, .region_hit,
    .hit_attribute_selector(hit_attr), .hit_attribute_high_table(hit_hi));
  hmpu_core_model core (.clk, .acc_valid, .acc_write, .acc_opc1, .acc_crn, .acc_crm,
    .acc_opc2, .acc_wdata, .acc_from_kernel, .acc_rdata, .acc_done, .acc_undef, .acc_trap);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic op(input logic w, input logic [3:0] crn, input logic [2:0] o1,
      input logic [3:0] crm, input logic [2:0] o2, input logic [31:0] wd, input logic k);
    core.access(w, o1, crn, crm, o2, wd, k, rd, und, trp);
  endtask
  task automatic mask(input logic w, input logic [31:0] wd, input logic k);
    op(w, 4'h6, 3'h4, 4'h1, 3'h1, wd, k);
  endtask
  task automatic ind(input logic w, input logic [31:0] wd);
    op(w, 4'h6, 3'h4, 4'h3, 3'h1, wd, 1'b0);
  endtask
  task automatic dir(input logic w, input logic [4:0] n, input logic lim,
      input logic [31:0] wd, input logic k);
    op(w, 4'h6, {2'h0, n[4]}, {1'b1, n[3:1]}, {n[0], 1'b0, lim}, wd, k);
  endtask
  task automatic wait2();
    @(negedge clk);
    @(negedge clk);
  endtask
  // Scenarios
  task automatic t_alias();
    mask(1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0, "mask after reset");
    chk(region_hit, 32'h0, "hits after reset");
    mask(1'b1, 32'h8000_0009, 1'b0);
    mask(1'b0, 32'h0, 1'b0);
    chk(rd, 32'h8000_0009, "mask readback");
    region_selector = 8'h03;
    ind(1'b0, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "enable seen in limit");
    ind(1'b1, 32'h0000_0030);
    ind(1'b0, 32'h0);
    chk(rd, 32'h0, "limit reserved bits");
    mask(1'b0, 32'h0, 1'b0);
    chk(rd, 32'h8000_0001, "mask after limit write");
    $display("test alias done");
  endtask
  task automatic t_direct();
    dir(1'b1, 5'd17, 1'b0, 32'h1234_567f, 1'b0);
    dir(1'b0, 5'd17, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h1234_5640, "direct base");
    chk({31'h0, und}, 32'h0, "direct encoding");
    dir(1'b1, 5'd17, 1'b1, 32'h1234_5ffb, 1'b0);
    dir(1'b0, 5'd17, 1'b1, 32'h0, 1'b0);
    chk(rd, 32'h1234_5fcb, "direct limit");
    region_selector = 8'h11;
    ind(1'b0, 32'h0);
    chk(rd, 32'h1234_5fcb, "indirect limit");
    mask(1'b0, 32'h0, 1'b0);
    chk(rd, 32'h8002_0001, "mask sees limit enable");
    $display("test direct done");
  endtask
  task automatic t_hit();
    logic [31:0] a[4] = '{32'h1234_563f, 32'h1234_5640, 32'h1234_5fff, 32'h1234_6000};
    mask(1'b1, 32'h0002_0000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk_addr = a[i];
      wait2();
      chk(region_hit, (i == 1 || i == 2) ? 32'h0002_0000 : 32'h0, "bounds");
    end
    chk_addr = a[1];
    wait2();
    chk({28'h0, hit_hi, hit_attr}, 32'hd, "attribute of hit");
    mask(1'b1, 32'h0, 1'b0);
    wait2();
    chk(region_hit, 32'h0, "disabled region");
    $display("test hit done");
  endtask
  task automatic t_trap();
    {hyp_present, trap_reg} = {1'b1, 32'h0000_0040};
    mask(1'b1, 32'hffff_ffff, 1'b1);
    chk({31'h0, trp}, 32'h1, "kernel mask trap");
    mask(1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0, "mask untouched");
    chk({31'h0, trp}, 32'h0, "hypervisor read not trapped");
    dir(1'b0, 5'd17, 1'b0, 32'h0, 1'b1);
    chk(rd, 32'h1234_5640, "kernel base allowed");
    trap_reg = 32'h0000_0400;
    dir(1'b0, 5'd17, 1'b0, 32'h0, 1'b1);
    chk({31'h0, trp}, 32'h1, "kernel base trap");
    hyp_present = 1'b0;
    dir(1'b0, 5'd17, 1'b0, 32'h0, 1'b1);
    chk({31'h0, trp}, 32'h0, "no hypervisor level");
    op(1'b0, 4'h5, 3'h4, 4'h1, 3'h1, 32'h0, 1'b0);
    chk({31'h0, und}, 32'h1, "bad register number");
    $display("test trap done");
  endtask
  task automatic t_reset();
    mask(1'b1, 32'h0002_0000, 1'b0);
    chk_addr = 32'h1234_5640;
    wait2();
    chk(region_hit, 32'h0002_0000, "hit before reset");
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(region_hit, 32'h0, "hits in reset");
    rst_n = 1'b1;
    mask(1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0, "mask after second reset");
    $display("test reset done");
  endtask
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 2000) begin
      fails++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    {rst_n, hyp_present, trap_reg, region_selector, chk_addr} = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_alias();
    t_direct();
    t_hit();
    t_trap();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
